// ===== src/bank_port_pkg.sv
package bank_port_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int AREA_W = 9;
    localparam int IMG_W  = 4;
    // bank 1 window: transmit area then receive area
    localparam logic [ADDR_W-1:0] TX_FIRST  = 11'h000;
    localparam logic [ADDR_W-1:0] TX_LAST   = 11'h1FF;
    localparam logic [ADDR_W-1:0] RX_FIRST  = 11'h200;
    localparam logic [ADDR_W-1:0] RX_LAST   = 11'h3FF;
    localparam int                AREA_WORDS = 'h200;
    // bank 0 window: cyclic link images
    localparam logic [ADDR_W-1:0] IMG_IN_FIRST  = 11'h000;
    localparam logic [ADDR_W-1:0] IMG_OUT_FIRST = 11'h010;
    // control and status, reachable in every bank
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 11'h400;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 11'h401;
    localparam int CTRL_BANK_A   = 0;
    localparam int CTRL_BANK_B   = 1;
    localparam int CTRL_REQUEST  = 2;
    localparam int CTRL_RESERVED = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int STAT_COMPLETE = 0;
    localparam int STAT_BUSY     = 1;
    localparam int STAT_BANK0    = 2;
    localparam int STAT_BANK1    = 3;
    localparam int STAT_STALLED  = 4;
    // transmit header word 0: index of the last word to send
    localparam int HDR_LAST_MSB = 8;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_RECV, ST_DONE} access_state_t;
endpackage

// ===== src/banked_transient_access_port.sv
// How it works
// - bank selects off,off gives 0; on,off gives 1
// - cyclic words frozen unless bank 0 selected
// - bank 1 transmit area words 0 to 1FFH
// - bank 1 receive area words 200H to 3FFH
// - request rising sends transmit area to slave
// - response stored, then access complete turns on
// - received header lands ahead of data words
`timescale 1ns/1ns
`default_nettype none
module banked_transient_access_port
    import bank_port_pkg::*;
#(
    parameter int IMG_WORDS = 16
) (
    input  wire logic                     core_clk,      // 100 MHz clock
    input  wire logic                     srst,          // synchronous reset, high
    input  wire logic [bank_port_pkg::ADDR_W-1:0] addr,  // register word address
    input  wire logic [bank_port_pkg::DATA_W-1:0] wdata, // write data
    input  wire logic                     wr,            // write strobe
    input  wire logic                     rd,            // read strobe
    output logic      [bank_port_pkg::DATA_W-1:0] rdata, // read data, cycle after rd
    output logic      [bank_port_pkg::DATA_W-1:0] tx_data, // word to slave station
    output logic                          tx_valid,      // tx_data valid
    output logic                          tx_last,       // last word of message
    input  wire logic                     tx_ready,      // slave takes word
    input  wire logic [bank_port_pkg::DATA_W-1:0] rx_data, // word from slave station
    input  wire logic                     rx_valid,      // rx_data valid
    input  wire logic                     rx_last,       // last response word
    input  wire logic                     cyc_in_valid,  // cyclic input word update
    input  wire logic [bank_port_pkg::IMG_W-1:0] cyc_in_idx, // cyclic input index
    input  wire logic [bank_port_pkg::DATA_W-1:0] cyc_in_word, // cyclic input word
    input  wire logic [bank_port_pkg::IMG_W-1:0] cyc_out_idx, // cyclic output index
    output logic      [bank_port_pkg::DATA_W-1:0] cyc_out_word, // cyclic output word
    output logic                          access_complete, // response stored
    output logic                          transient_access_request // request level
);
    import bank_port_pkg::*;

    logic [DATA_W-1:0] tx_mem [AREA_WORDS];
    logic [DATA_W-1:0] rx_mem [AREA_WORDS];
    logic [DATA_W-1:0] img_in [IMG_WORDS];
    logic [DATA_W-1:0] img_out [IMG_WORDS];

    logic [3:0]        ctrl;
    access_state_t     state;
    logic [AREA_W-1:0] tx_ptr;
    logic [AREA_W-1:0] rx_ptr;
    logic              req_q;
    logic              complete;

    // next values of the access sequencer
    access_state_t     next_state;
    logic [AREA_W-1:0] next_tx_ptr;
    logic [AREA_W-1:0] next_rx_ptr;
    logic              next_tx_valid;
    logic [DATA_W-1:0] next_tx_data;
    logic              next_complete;

    // bank decode
    wire bank0 = !ctrl[CTRL_BANK_A] && !ctrl[CTRL_BANK_B];
    wire bank1 = ctrl[CTRL_BANK_A] && !ctrl[CTRL_BANK_B];
    wire request = ctrl[CTRL_REQUEST];

    // address decode
    wire [AREA_W-1:0] area_off = addr[AREA_W-1:0];
    wire [IMG_W-1:0]  img_off  = addr[IMG_W-1:0];
    wire in_tx   = bank1 && addr >= TX_FIRST && addr <= TX_LAST;
    wire in_rx   = bank1 && addr >= RX_FIRST && addr <= RX_LAST;
    wire in_iimg = bank0 && addr >= IMG_IN_FIRST
                   && addr < IMG_IN_FIRST + ADDR_W'(IMG_WORDS);
    wire in_oimg = bank0 && addr >= IMG_OUT_FIRST
                   && addr < IMG_OUT_FIRST + ADDR_W'(IMG_WORDS);
    wire in_ctrl = addr == CTRL_ADDR;
    wire in_stat = addr == STAT_ADDR;

    // write enables; the receive area has none, only the slave fills it
    wire ctrl_write = wr && in_ctrl;
    wire tx_write   = wr && in_tx;
    wire oimg_write = wr && in_oimg;

    // status fields
    wire stat_busy      = state == ST_SEND || state == ST_RECV;
    wire stat_suspended = !bank0;

    wire [DATA_W-1:0] stat_word = {
        {(DATA_W-5){1'b0}},
        stat_suspended,
        ctrl[CTRL_BANK_B],
        ctrl[CTRL_BANK_A],
        stat_busy,
        complete
    };

    // read sources
    wire [DATA_W-1:0] tx_word   = tx_mem[area_off];
    wire [DATA_W-1:0] rx_word   = rx_mem[area_off];
    wire [DATA_W-1:0] iimg_word = img_in[img_off];
    wire [DATA_W-1:0] oimg_word = img_out[img_off];
    wire [DATA_W-1:0] ctrl_word = {{(DATA_W-4){1'b0}}, ctrl};

    wire [DATA_W-1:0] read_mux =
        in_tx   ? tx_word :
        in_rx   ? rx_word :
        in_iimg ? iimg_word :
        in_oimg ? oimg_word :
        in_ctrl ? ctrl_word :
        in_stat ? stat_word : '0;

    // cyclic image access, only while bank 0 is mapped
    wire cyc_in_fits  = 32'(cyc_in_idx) < IMG_WORDS;
    wire cyc_out_fits = 32'(cyc_out_idx) < IMG_WORDS;
    wire cyc_in_take  = cyc_in_valid && bank0 && cyc_in_fits;
    wire cyc_out_take = bank0 && cyc_out_fits;

    // message length comes from the first header word, so a header that
    // names a longer message than was written sends stale words
    wire [AREA_W-1:0] hdr_last   = tx_mem[0][HDR_LAST_MSB:0];
    wire [AREA_W-1:0] tx_ptr_inc = tx_ptr + AREA_W'(1);
    wire [AREA_W-1:0] rx_ptr_inc = rx_ptr + AREA_W'(1);
    wire              tx_at_last = tx_ptr == hdr_last;
    wire tx_fire  = tx_valid && tx_ready;
    wire rx_fire  = state == ST_RECV && rx_valid;
    wire req_rise = request && !req_q;

    assign tx_last = tx_valid && tx_at_last;
    assign access_complete = complete;
    assign transient_access_request = request;

    // register write path
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_write) begin
            ctrl <= wdata[3:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (tx_write) begin
            tx_mem[area_off] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (oimg_write) begin
            img_out[img_off] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata <= '0;
        end else if (rd) begin
            rdata <= read_mux;
        end
    end

    // cyclic refresh: image words hold still while another bank is mapped,
    // so each word keeps its last value until bank 0 is mapped again
    always_ff @(posedge core_clk) begin
        if (cyc_in_take) begin
            img_in[cyc_in_idx] <= cyc_in_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cyc_out_word <= '0;
        end else if (cyc_out_take) begin
            cyc_out_word <= img_out[cyc_out_idx];
        end
    end

    // response words go to the receive area in arrival order from its base,
    // so the control header always leads the data
    always_ff @(posedge core_clk) begin
        if (rx_fire) begin
            rx_mem[rx_ptr] <= rx_data;
        end
    end

    // access sequencer, next-state side
    always_comb begin
        next_state    = state;
        next_tx_ptr   = tx_ptr;
        next_rx_ptr   = rx_ptr;
        next_tx_valid = tx_valid;
        next_tx_data  = tx_data;
        next_complete = complete;
        case (state)
            ST_IDLE: begin
                // a rise while busy or done is ignored; the host must drop the
                // request first, so one level never starts two accesses
                if (req_rise) begin
                    next_state    = ST_SEND;
                    next_tx_ptr   = '0;
                    next_tx_data  = tx_mem[0];
                    next_tx_valid = 1'b1;
                end
            end
            ST_SEND: begin
                // each word holds until the slave takes it
                if (tx_fire) begin
                    if (tx_at_last) begin
                        next_tx_valid = 1'b0;
                        next_rx_ptr   = '0;
                        next_state    = ST_RECV;
                    end else begin
                        next_tx_ptr  = tx_ptr_inc;
                        next_tx_data = tx_mem[tx_ptr_inc];
                    end
                end
            end
            ST_RECV: begin
                if (rx_fire) begin
                    // a response longer than the area wraps onto its base
                    next_rx_ptr = rx_ptr_inc;
                    if (rx_last) begin
                        next_complete = 1'b1;
                        next_state    = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                // complete stays up until software drops the request
                if (!request) begin
                    next_complete = 1'b0;
                    next_state    = ST_IDLE;
                end
            end
            default: begin
                next_state    = ST_IDLE;
                next_tx_valid = 1'b0;
                next_complete = 1'b0;
            end
        endcase
    end

    // request edge detector; it idles low like the control bit after reset,
    // so no false edge follows reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            req_q <= 1'b0;
        end else begin
            req_q <= request;
        end
    end

    // access sequencer, state side
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state    <= ST_IDLE;
            tx_ptr   <= '0;
            rx_ptr   <= '0;
            tx_valid <= 1'b0;
            tx_data  <= '0;
            complete <= 1'b0;
        end else begin
            state    <= next_state;
            tx_ptr   <= next_tx_ptr;
            rx_ptr   <= next_rx_ptr;
            tx_valid <= next_tx_valid;
            tx_data  <= next_tx_data;
            complete <= next_complete;
        end
    end
endmodule
`default_nettype wire

// ===== verification/bank_port_chk.sv
`timescale 1ns/1ns
`default_nettype none
module bank_port_chk (
    input wire logic core_clk, srst, tx_valid, tx_last, tx_ready, rx_valid, rx_last,
    input wire logic access_complete, transient_access_request, input wire logic [15:0] tx_data
);
    wire logic req = transient_access_request;
    wire logic done = access_complete;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_req_send: assert property ($rose(req) && !done |-> ##[1:2] tx_valid)
        else $error("no send");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("word not held");
    a_last_drop: assert property (tx_valid && tx_last && tx_ready |=> !tx_valid)
        else $error("send overran");
    a_rx_done: assert property (rx_valid && rx_last && req && !done && !tx_valid |=> done)
        else $error("no complete");
    a_done_cause: assert property ($rose(done) |-> $past(rx_valid) && $past(rx_last))
        else $error("early complete");
    a_done_clear: assert property (!req |=> !done)
        else $error("stuck complete");
    a_done_quiet: assert property (done |-> !tx_valid)
        else $error("send in complete");
    c_stall: cover property (tx_valid && !tx_ready);
    c_done: cover property ($rose(done));
    c_clear: cover property ($fell(done));
endmodule
bind banked_transient_access_port bank_port_chk u_chk (.*);
`default_nettype wire

// ===== verification/slave_station_model.sv
`timescale 1ns/1ns
`default_nettype none
module slave_station_model (
    input wire logic core_clk, srst, tx_valid, tx_last, input wire logic [15:0] tx_data,
    output logic tx_ready = 0, rx_valid = 0, rx_last = 0, output logic [15:0] rx_data = '0
);
    logic [47:0] got = '0;
    int          k = -1;
    wire logic   take = tx_valid && tx_ready;
    // ready toggles so every word meets a stall; idle rx_last and rx_data toggle, rx_valid holds low
    always @(posedge core_clk) begin
        tx_ready <= !tx_ready && !srst;
        rx_valid <= k >= 0;
        rx_last <= k >= 0 ? k == 2 : !rx_last;
        rx_data <= k >= 0 ? 16'hA500 + 16'(k) : ~rx_data;
        if (take) got <= {got[31:0], tx_data};
        k <= srst || k == 2 ? -1 : take && tx_last ? 0 : k + int'(k >= 0);
    end
endmodule
`default_nettype wire

// ===== verification/banked_transient_access_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module banked_transient_access_port_tb_top;
    import bank_port_pkg::*;
    logic        core_clk = 0, srst = 1, wr = 0, rd = 0, cyc_in_valid = 1;
    logic        tx_valid, tx_last, tx_ready, rx_valid, rx_last;
    logic        access_complete, transient_access_request;
    logic [10:0] addr = '0;
    logic [3:0]  cyc_in_idx = 4'h3, cyc_out_idx = 4'h0;
    logic [15:0] wdata = '0, cyc_in_word = 16'h1111, rdata, tx_data, rx_data, cyc_out_word;
    int          err_total = 0, total_checks = 0;
    always #5 core_clk = ~core_clk;
    banked_transient_access_port u_dut (.*);
    slave_station_model u_slave (.*);
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        err_total += int'(got !== exp);
        if (got !== exp) $display("Error at %0t: %h not %h", $time, got, exp);
    endtask
    task automatic bus(input logic w, input logic [10:0] a, input logic [15:0] d);
        @(posedge core_clk);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        @(posedge core_clk);
        {wr, rd} <= 2'b00;
        #1 if (!w) chk(rdata, d);
    endtask
    task automatic t_map;
        bus(0, CTRL_ADDR, 16'h0000);
        bus(1, CTRL_ADDR, 16'h0001);
        bus(0, STAT_ADDR, 16'h0014);
        bus(1, TX_LAST, 16'hBEEF);
        bus(0, TX_LAST, 16'hBEEF);
        bus(1, CTRL_ADDR, 16'h0002);
        bus(0, TX_LAST, 16'h0000);
    endtask
    task automatic t_freeze;
        cyc_in_word <= 16'h2222;
        @(posedge core_clk) cyc_in_valid <= 0;
        bus(1, CTRL_ADDR, 16'h0000);
        bus(1, IMG_OUT_FIRST, 16'h3333);
        bus(0, 11'h003, 16'h1111);
        chk(cyc_out_word, 16'h3333);
    endtask
    task automatic t_access;
        logic [15:0] msg [3] = '{16'h0002, 16'h1234, 16'h5678};
        bus(1, CTRL_ADDR, 16'h0001);
        cyc_out_idx <= 4'h1;
        for (int i = 0; i < 3; i++) bus(1, 11'(i), msg[i]);
        bus(1, CTRL_ADDR, 16'h0005);
        chk(16'(transient_access_request), 16'h0001);
        for (int i = 0; i < 99 && access_complete !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        #1 chk(16'(access_complete), 16'h0001);
        chk(cyc_out_word, 16'h3333);
        for (int i = 0; i < 3; i++) chk(u_slave.got[47-16*i -: 16], msg[i]);
        for (int i = 0; i < 3; i++) bus(0, RX_FIRST + 11'(i), 16'hA500 + 16'(i));
        bus(1, CTRL_ADDR, 16'h0001);
        @(posedge core_clk) #1 chk(16'(access_complete), 16'h0000);
        bus(1, CTRL_ADDR, 16'h0000);
    endtask
    task automatic print_verdict(input int extra);
        $display("Checks %0d, errors %0d", total_checks, err_total + extra);
        if (err_total + extra == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial #20000 print_verdict(1);
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 0;
        t_map;
        t_freeze;
        t_access;
        print_verdict(0);
    end
endmodule
`default_nettype wire
